// ### include/vcr_defs.svh
// Constants for the VC0 resource configuration register group.
// Assumes byte addressing on a 32-bit Wishbone bus, one word per register.
`ifndef VCR_DEFS_SVH
`define VCR_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define VCR_ADDR_CAP        12'h150
`define VCR_ADDR_CTRL       12'h154
`define VCR_ADDR_STATE      12'h158

// ----------------------------------------------------------------------
// Field values and positions
// ----------------------------------------------------------------------
`define VCR_ARB_CAP_RST     8'h19
`define VCR_TSLOT_RST       7'h7f
`define VCR_TBL_OFS_RST     8'h04
`define VCR_TC_MAP_RST      8'hff
`define VCR_CHAN_ID         3'h0
`define VCR_SEL_DEFAULT     3'h0
`define VCR_SEL_WRR         3'h3
`define VCR_BIT_LOAD        16
`define VCR_BIT_EN          31

`endif

// ### include/vcr_pkg.sv
// Types for the VC0 resource configuration register group.
// Assumes the companion constants header is also included.
package vcr_pkg;

    // Wishbone request from the master
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [11:0] adr;
        logic [31:0] dat;
    } vcr_wb_req_t;

    // Live control settings handed to the switch core
    typedef struct packed {
        logic [7:0] tc_map;
        logic [2:0] arb_sel;
        logic       chan_en;
    } vcr_ctrl_t;

endpackage

// ### hdl/vcr_sel_filter.sv
// Arbitration-select filter: maps unsupported scheme codes to default.
// Assumes a purely combinational use by the register file.
`include "vcr_defs.svh"
module vcr_sel_filter
    import vcr_pkg::*;
(
    // Raw written value
    input  wire logic [2:0] sel_i,
    // Accepted value
    output logic      [2:0] sel_o
);
    // Only default and WRR survive a write
    always_comb begin
        if (sel_i == `VCR_SEL_WRR) begin
            sel_o = `VCR_SEL_WRR;
        end else begin
            sel_o = `VCR_SEL_DEFAULT;
        end
    end
endmodule

// ### hdl/vcr_byte_merge.sv
// Byte-lane write merge for one 32-bit register word.
// Assumes sel lanes follow the Wishbone byte-enable convention.
module vcr_byte_merge
    import vcr_pkg::*;
(
    // Old value, written data and lanes
    input  wire logic [31:0] old_i,
    input  wire logic [31:0] wdat_i,
    input  wire logic [3:0]  sel_i,
    // Merged value
    output logic      [31:0] new_o
);
    genvar g;
    // One lane per byte enable
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_lane
            assign new_o[g*8 +: 8] = sel_i[g] ? wdat_i[g*8 +: 8] : old_i[g*8 +: 8];
        end
    endgenerate
endmodule

// ### hdl/vcr_regs.sv
// VC0 resource capability, control and state registers on Wishbone.
// Assumes a classic Wishbone master; table storage and negotiation
// logic live in the switch core and talk over the core-side ports.
`include "vcr_defs.svh"
module vcr_regs
    import vcr_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Switch core side
    input  wire logic        tbl_entry_wr_i,
    input  wire logic        tbl_load_done_i,
    input  wire logic        negotiating_i,
    output logic             tbl_load_o,
    output vcr_ctrl_t        ctrl_o
);

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    vcr_wb_req_t req;
    logic        access;
    logic        wr_ctrl;
    logic        ack_r;

    assign req      = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i,
                        sel: wb_sel_i, adr: wb_adr_i, dat: wb_dat_i};
    // One-cycle answer; ack drops after each beat so a held request
    // is not taken twice
    assign access   = req.cyc && req.stb && !ack_r;
    assign wr_ctrl  = access && req.we && (req.adr == `VCR_ADDR_CTRL);
    assign wb_ack_o = ack_r;

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    logic [7:0]  tc_map_r;
    logic [2:0]  arb_sel_r;
    logic        chan_en_r;
    logic        tbl_load_r;
    logic        tbl_dirty_r;
    logic        negot_r;
    logic [31:0] ctrl_word;
    logic [31:0] ctrl_nxt;
    logic [2:0]  sel_ok;

    // Readback image before merge; load bit always 0
    assign ctrl_word = {chan_en_r, 4'h0, `VCR_CHAN_ID, 4'h0, arb_sel_r, 1'b0,
                        8'h00, tc_map_r};

    vcr_byte_merge u_merge (
        .old_i  (ctrl_word),
        .wdat_i (req.dat),
        .sel_i  (req.sel),
        .new_o  (ctrl_nxt)
    );

    vcr_sel_filter u_sel (
        .sel_i (ctrl_nxt[19:17]),
        .sel_o (sel_ok)
    );

    // Writable fields; reserved and ID bits are simply not stored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tc_map_r  <= `VCR_TC_MAP_RST;
            arb_sel_r <= `VCR_SEL_DEFAULT;
            chan_en_r <= 1'b1;
        end else if (wr_ctrl) begin
            tc_map_r  <= ctrl_nxt[7:0];
            arb_sel_r <= sel_ok;
            chan_en_r <= ctrl_nxt[`VCR_BIT_EN];
        end
    end

    // Load strobe: one-cycle pulse to the core, never stored for readback
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tbl_load_r <= 1'b0;
        end else begin
            tbl_load_r <= wr_ctrl && ctrl_nxt[`VCR_BIT_LOAD];
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Set wins over clear so an entry write racing a load is not lost
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tbl_dirty_r <= 1'b0;
        end else if (tbl_entry_wr_i) begin
            tbl_dirty_r <= 1'b1;
        end else if (tbl_load_done_i) begin
            tbl_dirty_r <= 1'b0;
        end
    end

    // Registered copy of the core's negotiation level
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            negot_r <= 1'b0;
        end else begin
            negot_r <= negotiating_i;
        end
    end

    // ------------------------------------------------------------------
    // Read path and acknowledge
    // ------------------------------------------------------------------
    logic [31:0] rd_word;

    // Unmapped addresses read zero and ignore writes
    always_comb begin
        case (req.adr)
            `VCR_ADDR_CAP: begin
                rd_word = {`VCR_TBL_OFS_RST, 1'b0, `VCR_TSLOT_RST, 1'b0, 1'b0,
                           6'h00, `VCR_ARB_CAP_RST};
            end
            `VCR_ADDR_CTRL:  rd_word = ctrl_word;
            `VCR_ADDR_STATE: rd_word = {14'h0000, negot_r, tbl_dirty_r, 16'h0000};
            default:         rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r    <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            ack_r    <= access;
            wb_dat_o <= access ? rd_word : 32'h0000_0000;
        end
    end

    assign tbl_load_o = tbl_load_r;
    assign ctrl_o     = '{tc_map: tc_map_r, arb_sel: arb_sel_r, chan_en: chan_en_r};

endmodule

// ### tb/vcr_regs_props.sv
// Port assertions for the VC0 resource register group.
// Assumes it is bound to vcr_regs, single clock, sync reset.
module vcr_regs_props
    import vcr_pkg::*;
(
    // Watched ports
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        negotiating_i,
    input wire logic        tbl_load_o,
    input wire vcr_ctrl_t   ctrl_o
);
    // ------------------------------------------------------------
    // Bus answers and field checks
    // ------------------------------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Taken request, read, control write with lane 2
    wire tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire rd = tk && !wb_we_i;
    wire cw = tk && wb_we_i && wb_adr_i == 12'h154 && wb_sel_i[2];
    property p_ack; tk |=> wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack late");
    property p_one; wb_ack_o |=> !wb_ack_o && wb_dat_o == 32'h0; endproperty
    a_one: assert property (p_one) else $error("ack held");
    property p_cap; rd && wb_adr_i == 12'h150 |=> wb_dat_o == 32'h047f0019; endproperty
    a_cap: assert property (p_cap) else $error("cap word");
    property p_ctl; rd && wb_adr_i == 12'h154 |=>
        wb_dat_o == {ctrl_o.chan_en, 11'h0, ctrl_o.arb_sel, 9'h0, ctrl_o.tc_map}; endproperty
    a_ctl: assert property (p_ctl) else $error("ctrl word");
    property p_ld; cw && wb_dat_i[16] |=> tbl_load_o; endproperty
    a_ld: assert property (p_ld) else $error("no load");
    property p_nold; !(cw && wb_dat_i[16]) |=> !tbl_load_o; endproperty
    a_nold: assert property (p_nold) else $error("stray load");
    property p_sel; cw |=> ctrl_o.arb_sel == (($past(wb_dat_i[19:17]) == 3'h3) ? 3'h3 : 3'h0);
    endproperty
    a_sel: assert property (p_sel) else $error("sel filter");
    property p_unm; rd && !(wb_adr_i inside {12'h150, 12'h154, 12'h158}) |=> wb_dat_o == 0;
    endproperty
    a_unm: assert property (p_unm) else $error("unmapped");
    // Pending flag is the core level registered once before the read is taken
    property p_neg; rd && wb_adr_i == 12'h158 |=> wb_dat_o[17] == $past(negotiating_i, 2);
    endproperty
    a_neg: assert property (p_neg) else $error("pending flag");
endmodule

bind vcr_regs vcr_regs_props u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .negotiating_i(negotiating_i),
    .tbl_load_o(tbl_load_o), .ctrl_o(ctrl_o));

// ### tb/vcr_regs_test.sv
// Self-checking bench for the VC0 resource register group.
// Assumes vcr_regs and its checker are compiled first.
module vcr_regs_test
    import vcr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    vcr_wb_req_t q = '0;
    logic [2:0]  core = 3'h0; // Negotiating, load done, entry written
    logic [31:0] dat_o, rv, dv, rnd = 32'ha94bb11f;
    logic        ack_o, ld_o, lv;
    vcr_ctrl_t   ctrl_o;
    logic [7:0]  m_map = 8'hff; // Reference model of the control word
    logic [2:0]  m_sel = 3'h0;
    logic        m_en = 1'b1;
    logic [3:0]  sv;
    int          mismatches = 0;
    int          compares = 0;
    vcr_regs DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(q.cyc), .wb_stb_i(q.stb),
        .wb_we_i(q.we), .wb_sel_i(q.sel), .wb_adr_i(q.adr), .wb_dat_i(q.dat),
        .wb_dat_o(dat_o), .wb_ack_o(ack_o), .tbl_entry_wr_i(core[0]),
        .tbl_load_done_i(core[1]), .negotiating_i(core[2]), .tbl_load_o(ld_o), .ctrl_o(ctrl_o));
    // 100 MHz clock
    always #5 clk_i = ~clk_i;
    // Random source: 32-bit Fibonacci shift register, one step per call
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // Classic cycle; values read before the edge are those sampled there
    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        q <= '{1'b1, 1'b1, w, s, a, d};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rv = dat_o;
        lv = ld_o;
        q <= '0;
        @(posedge clk_i);
    endtask
    task automatic pulse(input logic [2:0] v);
        core <= v;
        @(posedge clk_i);
        core <= v & 3'b100;
    endtask
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Watchdog: the sequence needs about 80 cycles
    initial begin
        repeat (3000) @(posedge clk_i);
        mismatches++;
        give_verdict();
    end
    // Main sequence
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b1, 12'h150, '1, 4'hf);
        wb(1'b1, 12'h15c, '1, 4'hf);
        wb(1'b0, 12'h150, 0, 4'hf);
        chk(rv, 32'h047f0019);
        wb(1'b0, 12'h15c, 0, 4'hf);
        chk(rv, 32'h0);
        $display("test reset_ro done");
        // Every select code, random payload; last pass writes lanes 0-1 only
        for (int k = 0; k < 9; k++) begin
            rnd = lfsr(rnd);
            dv = {rnd[31:20], k[2:0], rnd[16:0]};
            sv = (k == 8) ? 4'h3 : 4'hf;
            wb(1'b0, 12'h154, 0, 4'hf);
            chk(rv, {m_en, 11'h0, m_sel, 9'h0, m_map});
            wb(1'b1, 12'h154, dv, sv);
            chk({31'h0, lv}, {31'h0, dv[16] & sv[2]});
            if (sv[0]) m_map = dv[7:0];
            if (sv[2]) m_sel = (dv[19:17] == 3'h3) ? 3'h3 : 3'h0;
            if (sv[3]) m_en = dv[31];
            chk({20'h0, ctrl_o}, {20'h0, m_map, m_sel, m_en});
        end
        $display("test control done");
        pulse(3'b101);
        wb(1'b0, 12'h158, 0, 4'hf);
        chk(rv, 32'h00030000);
        pulse(3'b011);
        wb(1'b0, 12'h158, 0, 4'hf);
        chk(rv, 32'h00010000);
        pulse(3'b010);
        wb(1'b0, 12'h158, 0, 4'hf);
        chk(rv, 32'h0);
        $display("test status done");
        give_verdict();
    end
endmodule
